// ### dv/nand_dev_model.sv
// Behavioural NAND device on the far side of the host pins.
// Assumes the bench resolves the shared bus and pulls R/B# up.
`timescale 1ns/1ns
module nand_dev_model #(
	parameter int T_READ_NS = 1000,
	parameter int T_PROG_NS = 4000,
	parameter int T_REA_NS = 20
) (
	input wire nand_host_pkg::nand_pins_s PINS,
	input wire logic [7:0] IO_IN,
	output logic [7:0] IO_Q,
	output logic RB_PULL
);
	import nand_host_pkg::*;
	// ************************************************************
	// One page of array and its buffer
	// ************************************************************
	localparam int PAGE_BYTES = 2176;
	logic [7:0] page_mem [PAGE_BYTES];
	logic [7:0] buf_mem [PAGE_BYTES];
	int col = 0;
	int nadr = 0;
	int rd_idx = 0;
	logic lock_all = 1'b0;
	logic standby;
	assign standby = PINS.ce_n && !RB_PULL;
	initial begin
		IO_Q = 8'h00;
		RB_PULL = 1'b0;
		// Sampled once the host reset has settled; low or floating means no lock
		#30 lock_all = (PINS.prot === 1'b1);
	end
	// Busy delays block further WE strobes, as a busy device ignores them; RE strobes are still served
	always @(posedge PINS.we_n) begin
		if (!PINS.ce_n && PINS.cle) begin
			nadr = 0;
			if (IO_IN == 8'h30) begin
				RB_PULL = 1'b1;
				#(T_READ_NS);
				buf_mem = page_mem;
				RB_PULL = 1'b0;
			end else if (IO_IN == 8'h10 && PINS.wp_n && !lock_all) begin
				RB_PULL = 1'b1;
				#(T_PROG_NS);
				page_mem = buf_mem;
				RB_PULL = 1'b0;
			end
		end else if (!PINS.ce_n && PINS.ale) begin
			col = (nadr == 0) ? int'(IO_IN) : col + int'(IO_IN[3:0]) * 256;
			nadr++;
		end else if (!PINS.ce_n) begin
			buf_mem[col % PAGE_BYTES] = IO_IN;
			col++;
		end
	end
	always @(negedge PINS.re_n) begin
		if (!PINS.ce_n) begin
			rd_idx = col % PAGE_BYTES;
			col++;
			#(T_REA_NS) IO_Q = buf_mem[rd_idx];
		end
	end
	// Released bus shows the inverse so stale data cannot pass
	always @(posedge PINS.re_n) IO_Q = ~IO_Q;
endmodule

// ### dv/nand_host_tb.sv
// Self-checking bench for the NAND host controller with a device model.
// Assumes the AXI4-Lite timing and register map of the design package.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module nand_host_tb;
	import nand_host_pkg::*;
	localparam int NB = 8;
	logic MCLK = 1'b0;
	logic NRST = 1'b0;
	axil_req_s req = '0;
	axil_rsp_s rsp;
	nand_pins_s pins;
	logic [7:0] dev_q;
	logic rb_pull;
	wire logic [7:0] io_bus = !pins.io_oe_n ? pins.io_o : dev_q;
	wire logic rb_n = rb_pull ? 1'b0 : 1'b1;
	int n_mismatch = 0;
	int n_tests = 0;
	int seed = 37470;
	logic [31:0] rdat;
	logic [1:0] resp;
	int expq[$];
	always #20 MCLK = ~MCLK;
	nand_host i_nand_host (.MCLK(MCLK), .NRST(NRST), .AXI_REQ(req), .AXI_RSP(rsp),
		.NAND_OUT(pins), .NAND_IO_I(io_bus), .NAND_RB_N(rb_n));
	nand_dev_model i_nand_dev_model (.PINS(pins), .IO_IN(io_bus), .IO_Q(dev_q),
		.RB_PULL(rb_pull));
	// ************************************************************
	// Bus and operation tasks
	// ************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int t;
		t = 0;
		@(posedge MCLK);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= s;
		req.bready <= 1'b1;
		do begin
			@(posedge MCLK);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			t++;
		end while (!rsp.bvalid && t < 100);
		resp = rsp.bresp;
		req.bready <= 1'b0;
		if (t >= 100) n_mismatch++;
	endtask
	task automatic rd(input logic [7:0] a);
		int t;
		t = 0;
		@(posedge MCLK);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge MCLK);
			if (rsp.arready) req.arvalid <= 1'b0;
			t++;
		end while (!rsp.rvalid && t < 100);
		rdat = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
		if (t >= 100) n_mismatch++;
	endtask
	task automatic op(input nand_op_e o, input logic [7:0] b);
		int t;
		t = 0;
		wr(REG_CMD, {21'h0, o, b}, 4'hf);
		do begin
			rd(REG_STATUS);
			t++;
		end while (rdat[ST_DONE_BIT] !== 1'b1 && t < 500);
		wr(REG_STATUS, 32'h2, 4'hf);
		if (t >= 500) n_mismatch++;
	endtask
	task automatic hdr(input logic [7:0] c);
		op(OP_CMD, c);
		op(OP_ADDR, 8'h00);
		op(OP_ADDR, 8'h00);
	endtask
	task automatic prog(input bit keep);
		logic [7:0] v;
		hdr(8'h80);
		if (keep) expq = {};
		repeat (NB) begin
			v = 8'($random(seed));
			if (keep) expq.push_back(int'(v));
			op(OP_WDATA, v);
		end
		op(OP_CMD, 8'h10);
		rd(REG_STATUS);
		`CHK("rb_level", !keep, rdat[ST_RB_BIT])
		op(OP_WAITRB, 8'h00);
	endtask
	task automatic readback;
		hdr(8'h00);
		op(OP_CMD, 8'h30);
		op(OP_WAITRB, 8'h00);
		foreach (expq[i]) begin
			op(OP_RDATA, 8'h00);
			rd(REG_RXDATA);
			`CHK("rx_byte", 8'(expq[i]), rdat[7:0])
		end
	endtask
	task tally_and_finish;
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		repeat (3) @(posedge MCLK);
		NRST <= 1'b1;
		`CHK("ce_n_rst", 1'b1, pins.ce_n)
		`CHK("wp_n_rst", 1'b0, pins.wp_n)
		`CHK("prot_rst", 1'b0, pins.prot)
		rd(8'h10);
		`CHK("unmapped", RESP_DECERR, resp)
		rd(REG_CTRL);
		`CHK("ctrl_rst", 32'h0, rdat)
		wr(REG_CTRL, 32'h3, 4'hf);
		rd(REG_CTRL);
		`CHK("ce_n_on", 1'b0, pins.ce_n)
		// Low byte lane off: control must keep its value
		wr(REG_CTRL, 32'h0, 4'he);
		`CHK("ctrl_bresp", RESP_OKAY, resp)
		rd(REG_CTRL);
		`CHK("ctrl_strb", 32'h3, rdat)
		prog(1'b1);
		readback();
		// Second command lands while the first is still running
		wr(REG_CMD, {21'h0, OP_RDATA, 8'h00}, 4'hf);
		wr(REG_CMD, {21'h0, OP_RDATA, 8'h00}, 4'hf);
		rd(REG_STATUS);
		`CHK("refused", 1'b1, rdat[ST_REFUSED_BIT])
		wr(REG_STATUS, 32'ha, 4'hf);
		rd(REG_STATUS);
		`CHK("refused_clr", 1'b0, rdat[ST_REFUSED_BIT])
		wr(REG_CTRL, 32'h1, 4'hf);
		rd(REG_CTRL);
		`CHK("wp_n_low", 1'b0, pins.wp_n)
		prog(1'b0);
		wr(REG_CTRL, 32'h3, 4'hf);
		readback();
		tally_and_finish();
	end
	initial begin
		#(40 * 40000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule

// ### src/nand_host.sv
// Host-side controller for an 8-bit multiplexed asynchronous NAND device.
// Assumes software drives it over AXI4-Lite and the device sits on the pins.
`timescale 1ns/1ns

module nand_host (
	input wire logic MCLK,
	input wire logic NRST,
	input wire nand_host_pkg::axil_req_s AXI_REQ,
	output nand_host_pkg::axil_rsp_s AXI_RSP,
	output nand_host_pkg::nand_pins_s NAND_OUT,
	input wire logic [7:0] NAND_IO_I,
	input wire logic NAND_RB_N
);
	import nand_host_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SETUP = 5'b00010,
		ST_LOW = 5'b00100,
		ST_HIGH = 5'b01000,
		ST_WAITRB = 5'b10000
	} state_e;

	initial begin
		if (SETUP_CYC < 1 || WE_LOW_CYC < 1 || HOLD_CYC < 1 || RE_LOW_CYC > 15)
			$error("nand_host: strobe timing does not fit the counter");
	end

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [8:0] pins_s;
	wire [7:0] io_s = pins_s[7:0];
	wire rb_s = pins_s[8];

	pin_sync #(.WIDTH(9)) u_sync (
		.clk(MCLK),
		.rst_n(NRST),
		.d({NAND_RB_N, NAND_IO_I}),
		.q(pins_s)
	);

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic aw_got_r;
	logic w_got_r;
	logic [AXI_AW-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [2:0] ctrl_r;
	logic done_r;
	logic refused_r;
	logic [7:0] rx_r;
	state_e st_r;
	nand_op_e op_r;
	logic [3:0] cnt_r;
	logic done_set;

	wire commit = aw_got_r && w_got_r && !AXI_RSP.bvalid;
	wire lane0 = w_strb_r[0];
	wire lane1 = w_strb_r[1];
	wire ctrl_wr = commit && aw_addr_r == REG_CTRL && lane0;
	wire cmd_wr = commit && aw_addr_r == REG_CMD && lane0 && lane1;
	wire stat_wr = commit && aw_addr_r == REG_STATUS && lane0;
	wire busy = st_r != ST_IDLE;
	wire cmd_go = cmd_wr && !busy;
	wire cmd_refuse = cmd_wr && busy;
	wire wr_hit = aw_addr_r == REG_CTRL || aw_addr_r == REG_CMD || aw_addr_r == REG_STATUS;
	wire done_clr = stat_wr && w_data_r[ST_DONE_BIT];
	wire refused_clr = stat_wr && w_data_r[ST_REFUSED_BIT];
	wire [2:0] cmd_op = w_data_r[CMD_OP_LSB +: 3];
	wire rd_hit = AXI_REQ.araddr == REG_CTRL || AXI_REQ.araddr == REG_CMD
		|| AXI_REQ.araddr == REG_STATUS || AXI_REQ.araddr == REG_RXDATA;
	wire [31:0] status_word = {28'h0000000, refused_r, rb_s, done_r, busy};
	wire [31:0] rd_word = AXI_REQ.araddr == REG_CTRL ? {29'h00000000, ctrl_r} :
		AXI_REQ.araddr == REG_CMD ? {21'h000000, 3'(op_r), 8'h00} :
		AXI_REQ.araddr == REG_STATUS ? status_word :
		AXI_REQ.araddr == REG_RXDATA ? {24'h000000, rx_r} : 32'h00000000;

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			AXI_RSP <= '0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else begin
			if (AXI_RSP.awready && AXI_REQ.awvalid) begin
				AXI_RSP.awready <= 1'b0;
				aw_got_r <= 1'b1;
				aw_addr_r <= AXI_REQ.awaddr;
			end else if (!aw_got_r && !AXI_RSP.bvalid) begin
				AXI_RSP.awready <= 1'b1;
			end
			if (AXI_RSP.wready && AXI_REQ.wvalid) begin
				AXI_RSP.wready <= 1'b0;
				w_got_r <= 1'b1;
				w_data_r <= AXI_REQ.wdata;
				w_strb_r <= AXI_REQ.wstrb;
			end else if (!w_got_r && !AXI_RSP.bvalid) begin
				AXI_RSP.wready <= 1'b1;
			end
			if (commit) begin
				AXI_RSP.bvalid <= 1'b1;
				AXI_RSP.bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
			end else if (AXI_RSP.bvalid && AXI_REQ.bready) begin
				AXI_RSP.bvalid <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
			if (AXI_RSP.arready && AXI_REQ.arvalid) begin
				AXI_RSP.arready <= 1'b0;
				AXI_RSP.rvalid <= 1'b1;
				AXI_RSP.rdata <= rd_word;
				AXI_RSP.rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
			end else if (AXI_RSP.rvalid && AXI_REQ.rready) begin
				AXI_RSP.rvalid <= 1'b0;
			end else if (!AXI_RSP.rvalid) begin
				AXI_RSP.arready <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Control and status flags
	// ************************************************************
	// WP held low from reset until software releases it
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_r <= CTRL_RESET;
			done_r <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			if (ctrl_wr)
				ctrl_r <= w_data_r[2:0];
			// A new event beats a clear in the same cycle
			done_r <= done_set | (done_r & ~done_clr);
			refused_r <= cmd_refuse | (refused_r & ~refused_clr);
		end
	end

	// ************************************************************
	// Pin sequencer
	// ************************************************************
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			st_r <= ST_IDLE;
			op_r <= OP_CMD;
			cnt_r <= '0;
			rx_r <= '0;
			done_set <= 1'b0;
			NAND_OUT <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
				wp_n: 1'b0, prot: 1'b0, io_oe_n: 1'b1, io_o: 8'h00};
		end else begin
			done_set <= 1'b0;
			NAND_OUT.ce_n <= !ctrl_r[CTRL_CE_BIT];
			NAND_OUT.wp_n <= ctrl_r[CTRL_WP_BIT];
			NAND_OUT.prot <= ctrl_r[CTRL_PROT_BIT];
			case (st_r)
				ST_IDLE: begin
					if (cmd_go) begin
						op_r <= nand_op_e'(cmd_op);
						if (cmd_op == OP_WAITRB) begin
							st_r <= ST_WAITRB;
						end else if (cmd_op == OP_RDATA) begin
							// Bus stays released so only the device drives it
							NAND_OUT.re_n <= 1'b0;
							cnt_r <= 4'(RE_LOW_CYC);
							st_r <= ST_LOW;
						end else begin
							NAND_OUT.cle <= cmd_op == OP_CMD;
							NAND_OUT.ale <= cmd_op == OP_ADDR;
							NAND_OUT.io_o <= w_data_r[7:0];
							NAND_OUT.io_oe_n <= 1'b0;
							cnt_r <= 4'(SETUP_CYC);
							st_r <= ST_SETUP;
						end
					end
				end
				ST_SETUP: begin
					if (cnt_r == 4'h1) begin
						NAND_OUT.we_n <= 1'b0;
						cnt_r <= 4'(WE_LOW_CYC);
						st_r <= ST_LOW;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				ST_LOW: begin
					if (cnt_r == 4'h1) begin
						if (op_r == OP_RDATA) begin
							// Low time covers access delay plus synchroniser
							rx_r <= io_s;
							NAND_OUT.re_n <= 1'b1;
						end else begin
							NAND_OUT.we_n <= 1'b1;
						end
						cnt_r <= 4'(HOLD_CYC);
						st_r <= ST_HIGH;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				ST_HIGH: begin
					if (cnt_r == 4'h1) begin
						NAND_OUT.cle <= 1'b0;
						NAND_OUT.ale <= 1'b0;
						NAND_OUT.io_oe_n <= 1'b1;
						done_set <= 1'b1;
						st_r <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				ST_WAITRB: begin
					if (rb_s) begin
						done_set <= 1'b1;
						st_r <= ST_IDLE;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	property p_one_qualifier;
		!(NAND_OUT.cle && NAND_OUT.ale);
	endproperty
	a_one_qualifier: assert property (p_one_qualifier) else $error("CLE and ALE both high");

	property p_cle_cmd;
		!NAND_OUT.we_n && op_r == OP_CMD |-> NAND_OUT.cle && !NAND_OUT.io_oe_n;
	endproperty
	a_cle_cmd: assert property (p_cle_cmd) else $error("CLE low during command strobe");

	property p_ale_addr;
		!NAND_OUT.we_n && op_r == OP_ADDR |-> NAND_OUT.ale && !NAND_OUT.cle;
	endproperty
	a_ale_addr: assert property (p_ale_addr) else $error("ALE low during address strobe");

	property p_we_width;
		$fell(NAND_OUT.we_n) |-> !NAND_OUT.we_n [*2] ##1 NAND_OUT.we_n;
	endproperty
	a_we_width: assert property (p_we_width) else $error("WE low width wrong");

	property p_io_stable;
		!NAND_OUT.we_n ##1 NAND_OUT.we_n |-> $stable(NAND_OUT.io_o) && !NAND_OUT.io_oe_n;
	endproperty
	a_io_stable: assert property (p_io_stable) else $error("IO moved at WE rise");

	property p_re_width;
		$fell(NAND_OUT.re_n) |-> !NAND_OUT.re_n [*5] ##1 NAND_OUT.re_n ##1 done_set;
	endproperty
	a_re_width: assert property (p_re_width) else $error("RE pulse or done wrong");

	property p_no_drive_on_read;
		!NAND_OUT.re_n |-> NAND_OUT.io_oe_n && NAND_OUT.we_n;
	endproperty
	a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("Bus driven on read");

	property p_wp_release;
		$rose(NAND_OUT.wp_n) |-> $past(ctrl_r[CTRL_WP_BIT], 1) && $past(ctrl_wr, 2);
	endproperty
	a_wp_release: assert property (p_wp_release) else $error("WP rose without release");

	// Leaves the wait on exactly the cycle after synced ready was seen high
	property p_wait_ready;
		st_r == ST_WAITRB |=> done_set == $past(rb_s) && busy == !$past(rb_s);
	endproperty
	a_wait_ready: assert property (p_wait_ready) else $error("Wait ended while busy");

	c_cmd: cover property ($rose(NAND_OUT.we_n) && NAND_OUT.cle);
	c_addr: cover property ($rose(NAND_OUT.we_n) && NAND_OUT.ale);
	c_read: cover property ($rose(NAND_OUT.re_n) ##1 done_set);
	c_refuse: cover property (cmd_refuse);
endmodule

// ### src/nand_host_pkg.sv
// Shared constants and carrier types for the NAND pin-level host controller.
// Assumes a 25 MHz clock and an AXI4-Lite master with 32-bit data.
package nand_host_pkg;

	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] REG_CMD = 8'h04;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
	localparam logic [AXI_AW-1:0] REG_RXDATA = 8'h0c;
	localparam int CTRL_CE_BIT = 0;
	localparam int CTRL_WP_BIT = 1;
	localparam int CTRL_PROT_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int CMD_OP_LSB = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_RB_BIT = 2;
	localparam int ST_REFUSED_BIT = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_NS = 40;
	localparam int T_SETUP_NS = 40;
	localparam int T_WE_LOW_NS = 50;
	localparam int T_HOLD_NS = 30;
	localparam int T_REA_NS = 40;
	localparam int SYNC_LAT = 3;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RE_LOW_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT + 1;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		OP_CMD = 3'h0,
		OP_ADDR = 3'h1,
		OP_WDATA = 3'h2,
		OP_RDATA = 3'h3,
		OP_WAITRB = 3'h4
	} nand_op_e;

	typedef struct packed {
		logic awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_AW-1:0] araddr;
		logic rready;
	} axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_s;

	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic wp_n;
		logic prot;
		logic io_oe_n;
		logic [7:0] io_o;
	} nand_pins_s;

endpackage

// ### src/pin_sync.sv
// Three-stage synchroniser for pins arriving from outside the clock domain.
// Assumes each bit is independent; output changes once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	initial begin
		if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Hold the old value while the last two stages disagree
			q <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
		end
	end
endmodule
